// ---- logic/conv_regs.sv ----
// Result word, conversion interval timers and offset registers of the converter.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1: Channel 3 under-range sets bit 15 of the result word.
// R2: Channel 3 over-range sets bit 14 of the result word.
// R3: Channel 3 watchdog timeout sets bit 13 of the result word.
// R4: Channel 3 amplitude fault sets bit 12 of the result word.
// R5: Reading the result word clears its error flags; flags reset to zero.
// R6: Result bits 11 to 0 hold the read-only 12-bit result, reset zero.
// R7: Channel 0 interval is 16-bit read/write, resets 0x0080; 0 to 4 reserved.
// R8: A conversion lasts sixteen times the interval in reference clock periods.
// R9: Channels 1 to 3 have their own interval registers, same behaviour.
// R10: Channel 0 offset is 16-bit read/write, resets zero, scaled by 2^-16.
// R11: Channels 1 and 2 have their own offset registers, reset zero.
// R12: Amplitude fault raised if unsettled at conversion start and reporting on.
// R13: A flag stays set until the next read of the result word.
// R14: Channel 3 registers exist only in the four-channel build; channel 2 registers need at least three channels.
module conv_regs #(
    parameter int NUM_CH = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [conv_regs_pkg::ADDR_W-1:0] addr,
    input wire logic [conv_regs_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [conv_regs_pkg::DATA_W-1:0] rdata,
    input wire logic [3:0] ref_tick,
    input wire conv_regs_pkg::ch3_evt_t ch3_evt,
    input wire logic amp_unsettled,
    output logic [3:0][15:0] conv_interval,
    output logic [2:0][15:0] freq_shift,
    output logic [3:0] conv_start,
    output logic [3:0] conv_done,
    output logic irq
);
    import conv_regs_pkg::*;

    state_t r;
    state_t n;

    always_comb begin
        logic [15:0] per;
        logic [19:0] last;
        logic [3:0] err_new;
        logic [7:0] sts_set;
        logic [7:0] sts_clr;
        logic rd_res;
        logic ch3_on;
        per = 16'h0000;
        last = 20'h00000;
        err_new = 4'h0;
        sts_set = 8'h00;
        sts_clr = 8'h00;
        n = r;
        ch3_on = (NUM_CH > 3);
        rd_res = rd && (addr == ADDR_RESULT_CH3) && ch3_on;

        // The first stage only feeds the second, so a metastable level stays contained.
        n.amp_sync = {r.amp_sync[0], amp_unsettled};

        // Interval timers run on reference ticks while the channel is enabled.
        n.start = 4'h0;
        n.done = 4'h0;
        for (int c = 0; c < 4; c++) begin
            per = (r.ivl[c] < IVL_MIN) ? IVL_MIN : r.ivl[c];
            last = {per, 4'h0} - 20'h00001; // R8
            if (c >= NUM_CH || !r.ctrl[CTRL_RUN_LSB + c]) begin
                n.tmr[c] = 20'h00000;
            end else if (ref_tick[c]) begin
                if (r.tmr[c] == 20'h00000) begin
                    n.start[c] = 1'b1;
                end
                if (r.tmr[c] >= last) begin
                    n.tmr[c] = 20'h00000; // R8
                    n.done[c] = 1'b1;
                end else begin
                    n.tmr[c] = r.tmr[c] + 20'h00001;
                end
            end
        end

        // Channel 3 error detection.
        if (ch3_on) begin
            err_new[UR_BIT - AE_BIT] = ch3_evt.under; // R1
            err_new[OR_BIT - AE_BIT] = ch3_evt.over; // R2
            err_new[WD_BIT - AE_BIT] = ch3_evt.wdog; // R3
            err_new[0] = n.start[3] && r.ctrl[CTRL_AMP_EN_BIT] && r.amp_sync[1]; // R4 R12
            if (ch3_evt.valid) begin
                n.result = ch3_evt.data; // R6
            end
        end

        // A read clears the flags, but an error in the same cycle survives it.
        n.flags = (rd_res ? RST_FLAGS : r.flags) | err_new; // R5 R13

        // Register writes; absent channels ignore them.
        if (wr) begin
            for (int c = 0; c < 4; c++) begin
                if (addr == ADDR_IVL[c] && c < NUM_CH) begin
                    n.ivl[c] = wdata; // R7 R9 R14
                end
            end
            for (int c = 0; c < 3; c++) begin
                if (addr == ADDR_SHIFT[c] && c < NUM_CH) begin
                    n.shift[c] = wdata; // R10 R11 R14
                end
            end
            if (addr == ADDR_CTRL) begin
                n.ctrl = wdata[7:0];
            end
            if (addr == ADDR_IRQ_STS) begin
                sts_clr = wdata[7:0];
            end
            if (addr == ADDR_IRQ_MASK) begin
                n.mask = wdata[7:0];
            end
        end

        // Sticky interrupt status; a new event beats a write-one-to-clear.
        sts_set[STS_DONE_LSB +: 4] = n.done;
        sts_set[STS_ERR3_BIT] = |err_new;
        n.sts = (r.sts & ~sts_clr) | sts_set;
        n.irq = |(n.sts & n.mask);

        // Read data stands for exactly one cycle after the strobe.
        n.rdata = 16'h0000;
        if (rd) begin
            if (rd_res) begin
                n.rdata[UR_BIT] = r.flags[UR_BIT - AE_BIT]; // R1
                n.rdata[OR_BIT] = r.flags[OR_BIT - AE_BIT]; // R2
                n.rdata[WD_BIT] = r.flags[WD_BIT - AE_BIT]; // R3
                n.rdata[AE_BIT] = r.flags[0]; // R4
                n.rdata[RES_W-1:0] = r.result; // R6
            end
            for (int c = 0; c < 4; c++) begin
                if (addr == ADDR_IVL[c] && c < NUM_CH) begin
                    n.rdata = r.ivl[c]; // R7 R9
                end
            end
            for (int c = 0; c < 3; c++) begin
                if (addr == ADDR_SHIFT[c] && c < NUM_CH) begin
                    n.rdata = r.shift[c]; // R10 R11
                end
            end
            if (addr == ADDR_CTRL) begin
                n.rdata = {8'h00, r.ctrl};
            end
            if (addr == ADDR_IRQ_STS) begin
                n.rdata = {8'h00, r.sts};
            end
            if (addr == ADDR_IRQ_MASK) begin
                n.rdata = {8'h00, r.mask};
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= STATE_RST;
        end else begin
            r <= n;
        end
    end

    // The offsets are handed to the core unscaled; it applies the 2^-16 weight.
    assign rdata = r.rdata;
    assign conv_interval = r.ivl;
    assign freq_shift = r.shift;
    assign conv_start = r.start;
    assign conv_done = r.done;
    assign irq = r.irq;

endmodule // conv_regs

`default_nettype wire

// ---- logic/conv_regs_pkg.sv ----
// Shared constants and types of the conversion result and timing register slice.
package conv_regs_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int RES_W = 12;
    localparam int TMR_W = 20;

    // Register offsets, one address unit per 16-bit register.
    localparam logic [7:0] ADDR_RESULT_CH3 = 8'h06;
    localparam logic [3:0][7:0] ADDR_IVL = {8'h0B, 8'h0A, 8'h09, 8'h08};
    localparam logic [2:0][7:0] ADDR_SHIFT = {8'h0E, 8'h0D, 8'h0C};
    localparam logic [7:0] ADDR_CTRL = 8'h30;
    localparam logic [7:0] ADDR_IRQ_STS = 8'h31;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h32;

    // Error flag positions inside the channel 3 result word.
    localparam int UR_BIT = 15;
    localparam int OR_BIT = 14;
    localparam int WD_BIT = 13;
    localparam int AE_BIT = 12;

    // Control register fields.
    localparam int CTRL_RUN_LSB = 0;
    localparam int CTRL_AMP_EN_BIT = 4;

    // Interrupt status fields.
    localparam int STS_DONE_LSB = 0;
    localparam int STS_ERR3_BIT = 4;

    // Reset values.
    localparam logic [15:0] RST_IVL = 16'h0080;
    localparam logic [15:0] RST_SHIFT = 16'h0000;
    localparam logic [11:0] RST_RESULT = 12'h000;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;

    // Interval arithmetic: counts below the least legal value run as it.
    localparam logic [15:0] IVL_MIN = 16'h0005;
    localparam int IVL_SCALE_SH = 4;

    // Channel 3 results and errors reported by the conversion core.
    typedef struct packed {
        logic valid;
        logic [11:0] data;
        logic under;
        logic over;
        logic wdog;
    } ch3_evt_t;

    typedef struct packed {
        logic [15:0] rdata;
        logic [3:0] flags;
        logic [11:0] result;
        logic [3:0][15:0] ivl;
        logic [2:0][15:0] shift;
        logic [3:0][19:0] tmr;
        logic [3:0] start;
        logic [3:0] done;
        logic [7:0] ctrl;
        logic [7:0] sts;
        logic [7:0] mask;
        logic irq;
        logic [1:0] amp_sync;
    } state_t;

    localparam state_t STATE_RST = '{
        rdata: 16'h0000,
        flags: RST_FLAGS,
        result: RST_RESULT,
        ivl: {4{RST_IVL}},
        shift: {3{RST_SHIFT}},
        tmr: {4{20'h00000}},
        start: 4'h0,
        done: 4'h0,
        ctrl: RST_CTRL,
        sts: 8'h00,
        mask: RST_MASK,
        irq: 1'b0,
        amp_sync: 2'h0
    };

endpackage

// ---- sim/conv_regs_properties.sv ----
// Concurrent checks on the result word, the interval registers and the channel 0 timer start.
`timescale 1ns/100ps
`default_nettype none
module conv_regs_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic [3:0] ref_tick,
    input wire conv_regs_pkg::ch3_evt_t ch3_evt,
    input wire logic [3:0][15:0] conv_interval,
    input wire logic [3:0] conv_start
);
    import conv_regs_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence rd_res;
        rd && addr == ADDR_RESULT_CH3;
    endsequence
    // A quiet read sees no new error in its own cycle, so it must clear.
    sequence quiet_rd;
        rd && addr == ADDR_RESULT_CH3 && ch3_evt[2:0] == 3'h0;
    endsequence
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero");
    a_under_flag: assert property (ch3_evt.under ##1 rd_res |=> rdata[UR_BIT])
        else $error("under flag missing");
    a_over_flag: assert property (ch3_evt.over ##1 rd_res |=> rdata[OR_BIT])
        else $error("over flag missing");
    a_wdog_flag: assert property (ch3_evt.wdog ##1 rd_res |=> rdata[WD_BIT])
        else $error("timeout flag missing");
    a_result_load: assert property (ch3_evt.valid ##1 rd_res |=>
        rdata[11:0] == $past(ch3_evt.data, 2)) else $error("result wrong");
    a_flag_clear: assert property (quiet_rd ##1 ch3_evt[2:0] == 3'h0 ##1 quiet_rd
        |=> rdata[15:13] == 3'h0) else $error("flags not cleared");
    a_start_tick: assert property (conv_start[0] |-> $past(ref_tick[0]))
        else $error("start without tick");
    a_ivl_write: assert property (wr && addr == ADDR_IVL[0] |=>
        conv_interval[0] == $past(wdata)) else $error("interval write lost");
    a_ivl_hold: assert property (!wr |=> $stable(conv_interval))
        else $error("interval changed");
endmodule // conv_regs_properties
bind conv_regs conv_regs_properties chk (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .ref_tick, .ch3_evt, .conv_interval, .conv_start);
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the result word, interval timers and offset registers.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import conv_regs_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, amp = 1'b0, irq;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [3:0] ref_tick = 4'h0, conv_start, conv_done;
    ch3_evt_t ch3_evt = '0;
    logic [3:0][15:0] conv_interval;
    logic [2:0][15:0] freq_shift;
    int n_errors = 0, check_count = 0, n;
    conv_regs dut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .ref_tick, .ch3_evt,
        .amp_unsettled(amp), .conv_interval, .freq_shift, .conv_start, .conv_done, .irq);
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read data stand only in the cycle after the strobe, so look mid-cycle.
    task automatic rreg(input logic [7:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
        @(posedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic run_ivl(input logic [15:0] v, input int e);
        wreg(ADDR_IVL[0], v);
        for (n = 1; n < 300; n++) begin
            ref_tick <= 4'h9;
            @(posedge clk);
            ref_tick <= 4'h0;
            @(negedge clk);
            if (n == 1) chk({15'h0000, conv_start[0]}, 16'h0001);
            if (conv_done[0] === 1'b1) break;
            @(posedge clk);
        end
        @(posedge clk);
        chk(16'(n), 16'(e));
        if (n == 300) final_report();
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) rreg(ADDR_IVL[i], RST_IVL);
        for (int i = 0; i < 3; i++) rreg(ADDR_SHIFT[i], RST_SHIFT);
        rreg(ADDR_RESULT_CH3, 16'h0000);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            wreg(ADDR_IVL[i], 16'hFFFF - 16'(i));
            rreg(ADDR_IVL[i], 16'hFFFF - 16'(i));
            chk(conv_interval[i], 16'hFFFF - 16'(i));
        end
        for (int i = 0; i < 3; i++) begin
            wreg(ADDR_SHIFT[i], 16'h8001 + 16'(i));
            rreg(ADDR_SHIFT[i], 16'h8001 + 16'(i));
            chk(freq_shift[i], 16'h8001 + 16'(i));
        end
        wreg(8'h0F, 16'hFFFF);
        rreg(8'h0F, 16'h0000);
        $display("read write done");
        // The first three passes read at once, the last three wait three cycles to show that the flags hold.
        for (int i = 0; i < 6; i++) begin
            ch3_evt <= {1'b1, 12'hABC, 3'b100 >> (i % 3)};
            @(posedge clk);
            ch3_evt <= '0;
            repeat (3 * (i / 3)) @(posedge clk);
            rreg(ADDR_RESULT_CH3, {4'h8 >> (i % 3), 12'hABC});
            rreg(ADDR_RESULT_CH3, 16'h0ABC);
        end
        $display("error flags done");
        amp <= 1'b1;
        wreg(ADDR_IVL[3], 16'h0005);
        wreg(ADDR_IRQ_MASK, 16'h0010);
        wreg(ADDR_CTRL, 16'h0019);
        run_ivl(16'h0005, 80);
        run_ivl(16'h0007, 112);
        run_ivl(16'h0006, 96);
        @(negedge clk);
        chk({15'h0000, irq}, 16'h0001);
        @(posedge clk);
        rreg(ADDR_RESULT_CH3, 16'h1ABC);
        wreg(ADDR_IRQ_STS, 16'h001F);
        @(negedge clk);
        chk({15'h0000, irq}, 16'h0000);
        $display("interval and amplitude done");
        final_report();
    end
endmodule // tb
`default_nettype wire
